// ### inc/hbp_pkg.sv
// Package: constants and carrier types for the half-bridge protection and mode block
package hbp_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CLK_HZ = 25_000_000;
  // Deglitch times in ns, converted to cycles (least times round up)
  localparam int unsigned STATIC_DEGLITCH_NS = 5000;
  localparam int unsigned DYNAMIC_DEGLITCH_NS = 200;
  localparam int unsigned PRECHARGE_NS = 400;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned STATIC_DEGLITCH_CYC = (STATIC_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DYNAMIC_DEGLITCH_CYC = (DYNAMIC_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  // Detection delay: base plus step times the selector, in ns
  localparam int unsigned DETECT_DELAY_BASE_NS = 400;
  localparam int unsigned DETECT_DELAY_STEP_NS = 400;
  localparam int unsigned DETECT_DELAY_BASE_CYC = (DETECT_DELAY_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DETECT_DELAY_STEP_CYC = (DETECT_DELAY_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 10;
  localparam logic [2:0] THRESHOLD_RESET = 3'h0;
  localparam logic [3:0] DELAY_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_NORMAL,
    MODE_FAILSAFE
  } hbp_mode_type;

  // Per-channel configuration B fields
  typedef struct packed {
    logic [2:0] overload_threshold_sel;
    logic [3:0] detect_delay_sel;
  } hbp_cfg_type;

  // Per-channel gate command from the switching sequencer
  typedef struct packed {
    logic high_on;
    logic low_on;
  } hbp_gate_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_PRECHARGE,
    PH_DELAY,
    PH_ON
  } hbp_phase_type;
endpackage : hbp_pkg

// ### verilog/hbp_ctrl.sv
// Module: overload protection, OFF-state test currents and operating mode control
// Overview of operation
// - Static overload after delay latches bridge off
// - Static overload sets quick status and flag
// - Per-channel three-bit overload threshold select
// - One four-bit detection delay per channel
// - High-side delay starts after precharge ends
// - Low-side delay starts with gate turn-on
// - Uncrossed node at delay end trips bridge
// - Crossed node keeps switches on, no flag
// - Static and dynamic share the same flags
// - Fault holds until flag read and re-enable, or normal entry
// - Test currents only in normal, no global fault
// - Any test current kills high-side active pulldowns
// - High and low test currents may coexist
// - Test sources only on odd bridges
// - Live node state readable in eight bits
// - Sleep after power-on, outputs disabled
// - Reset input rising wakes into normal
// - Normal entry clears settings, sets reset flag
// - Failsafe when awake and serial fail or request
// - Failsafe disables gates, tests, pump, writes
// - Status kept and readable in failsafe
// - Watchdog toggle with request and serial fail low exits failsafe
`timescale 1ns/1ps
`default_nettype none
module hbp_ctrl #(
  parameter int unsigned NUM_CH = hbp_pkg::NUM_CH
) (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // Mode control pins and serial link status
  input wire logic RESET_N_IN,
  input wire logic FAILSAFE_REQUEST_IN,
  input wire logic SERIAL_FAILURE,
  input wire logic WATCHDOG_TOGGLE_BIT,
  input wire logic GLOBAL_FAULT,
  // Control writes (taken when CFG_WE is high in normal mode)
  input wire logic CFG_WE,
  input wire hbp_pkg::hbp_cfg_type [NUM_CH-1:0] CFG_IN,
  input wire logic [NUM_CH-1:0] BRIDGE_ENABLE_BIT,
  input wire logic [5:0] DIAG_CONTROL_IN,
  // Gate requests and sensing
  input wire hbp_pkg::hbp_gate_type [NUM_CH-1:0] GATE_REQ,
  input wire logic [NUM_CH-1:0] HIGH_OVERLOAD_CMP,
  input wire logic [NUM_CH-1:0] LOW_OVERLOAD_CMP,
  input wire logic [NUM_CH-1:0] NODE_RISE_CMP,
  input wire logic [NUM_CH-1:0] NODE_FALL_CMP,
  input wire logic [2*NUM_CH-1:0] BRIDGE_NODE_SENSE,
  // Status reads and flag clears
  input wire logic [NUM_CH-1:0] OVERLOAD_READ_CLR,
  // Outputs, with the reset flag read clear input
  output logic [NUM_CH-1:0] HIGH_SIDE_GATE_OUT,
  output logic [NUM_CH-1:0] LOW_SIDE_GATE_OUT,
  output logic [NUM_CH-1:0] HIGH_ACTIVE_PULLDOWN_EN,
  output logic [NUM_CH-1:0] HIGH_TEST_CURRENT_EN,
  output logic [NUM_CH-1:0] LOW_TEST_CURRENT_EN,
  output logic SWITCHED_PUMP_OUT,
  output logic PUMP_EN,
  output logic WRITE_ACCEPT,
  output hbp_pkg::hbp_mode_type MODE,
  output hbp_pkg::hbp_cfg_type [NUM_CH-1:0] CFG_OUT,
  output logic [NUM_CH-1:0] HIGH_OVERLOAD_FLAG,
  output logic [NUM_CH-1:0] LOW_OVERLOAD_FLAG,
  output logic [NUM_CH-1:0] BRIDGE_QUICK_STATUS,
  output logic RESET_OCCURRED_FLAG,
  input wire logic RESET_FLAG_READ_CLR,
  output logic [7:0] NODE_STATUS_REG
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops on every pin-side input except GLOBAL_FAULT
  localparam int unsigned SW = 4 + 4 * NUM_CH + 2 * NUM_CH;
  logic [SW-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic rst_s, fsr_s, spf_s, wd_s;
  logic [NUM_CH-1:0] hcmp_s, lcmp_s, rise_s, fall_s;
  logic [2*NUM_CH-1:0] node_s;

  always_comb begin
    sync1_d = {RESET_N_IN, FAILSAFE_REQUEST_IN, SERIAL_FAILURE, WATCHDOG_TOGGLE_BIT,
               HIGH_OVERLOAD_CMP, LOW_OVERLOAD_CMP, NODE_RISE_CMP, NODE_FALL_CMP,
               BRIDGE_NODE_SENSE};
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (CLK_EN) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign {rst_s, fsr_s, spf_s, wd_s, hcmp_s, lcmp_s, rise_s, fall_s, node_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Operating mode machine
  hbp_pkg::hbp_mode_type mode_q, mode_d;
  logic rst_prev_q, rst_prev_d, wd_prev_q, wd_prev_d, rcf_q, rcf_d, clear_all;

  always_comb begin
    mode_d = mode_q;
    rst_prev_d = rst_s;
    wd_prev_d = wd_s;
    clear_all = 1'b0;
    unique case (mode_q)
      hbp_pkg::MODE_SLEEP: begin
        if (rst_s && !rst_prev_q) begin
          mode_d = hbp_pkg::MODE_NORMAL;
          clear_all = 1'b1;
        end
      end
      hbp_pkg::MODE_NORMAL: begin
        if (!rst_s) begin
          mode_d = hbp_pkg::MODE_SLEEP;
        end else if (spf_s || fsr_s) begin
          mode_d = hbp_pkg::MODE_FAILSAFE;
        end
      end
      hbp_pkg::MODE_FAILSAFE: begin
        if (!rst_s) begin
          mode_d = hbp_pkg::MODE_SLEEP;
        end else if (!fsr_s && !spf_s && (wd_s != wd_prev_q)) begin
          mode_d = hbp_pkg::MODE_NORMAL;
          clear_all = 1'b1;
        end
      end
    endcase
    // Set wins over a same-cycle read clear
    rcf_d = clear_all ? 1'b1 : (RESET_FLAG_READ_CLR ? 1'b0 : rcf_q);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= hbp_pkg::MODE_SLEEP;
      rst_prev_q <= 1'b0;
      wd_prev_q <= 1'b0;
      rcf_q <= 1'b0;
    end else if (CLK_EN) begin
      mode_q <= mode_d;
      rst_prev_q <= rst_prev_d;
      wd_prev_q <= wd_prev_d;
      rcf_q <= rcf_d;
    end
  end

  logic normal;
  assign normal = (mode_q == hbp_pkg::MODE_NORMAL);

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers: writes only in normal mode, cleared on normal entry
  hbp_pkg::hbp_cfg_type [NUM_CH-1:0] cfg_q, cfg_d;
  logic [NUM_CH-1:0] en_q, en_d;
  logic [5:0] diag_q, diag_d;

  always_comb begin
    cfg_d = cfg_q;
    en_d = en_q;
    diag_d = diag_q;
    if (clear_all || mode_q == hbp_pkg::MODE_SLEEP) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_d[i].overload_threshold_sel = hbp_pkg::THRESHOLD_RESET;
        cfg_d[i].detect_delay_sel = hbp_pkg::DELAY_RESET;
      end
      en_d = '0;
      diag_d = '0;
    end else if (CFG_WE && normal) begin
      cfg_d = CFG_IN;
      en_d = BRIDGE_ENABLE_BIT;
      diag_d = DIAG_CONTROL_IN;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= '0;
      en_q <= '0;
      diag_q <= '0;
    end else if (CLK_EN) begin
      cfg_q <= cfg_d;
      en_q <= en_d;
      diag_q <= diag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel switching phase, overload detection and fault latch
  logic [NUM_CH-1:0] hflag_q, lflag_q, qsb_q, tripped_q, hg_q, lg_q;
  logic [NUM_CH-1:0] hflag_d, lflag_d, qsb_d, tripped_d, hg_d, lg_d;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    hbp_pkg::hbp_phase_type ph_q, ph_d;
    logic [hbp_pkg::CNT_W-1:0] cnt_q, cnt_d, dly_cyc;
    logic [hbp_pkg::CNT_W-1:0] sdg_q, sdg_d;
    logic is_high_q, is_high_d, want_h, want_l, allowed, trip_dyn, trip_stat, cmp;

    // Delay count from selector
    assign dly_cyc = hbp_pkg::CNT_W'(hbp_pkg::DETECT_DELAY_BASE_CYC
                     + hbp_pkg::DETECT_DELAY_STEP_CYC * cfg_q[c].detect_delay_sel);
    assign allowed = normal && en_q[c] && !tripped_q[c];
    assign want_h = allowed && GATE_REQ[c].high_on;
    assign want_l = allowed && GATE_REQ[c].low_on && !GATE_REQ[c].high_on;
    assign cmp = is_high_q ? hcmp_s[c] : lcmp_s[c];

    // Phase sequencer; a request drop returns to idle at once
    always_comb begin
      ph_d = ph_q;
      cnt_d = cnt_q;
      is_high_d = is_high_q;
      sdg_d = '0;
      trip_dyn = 1'b0;
      trip_stat = 1'b0;
      unique case (ph_q)
        hbp_pkg::PH_IDLE: begin
          if (want_h) begin
            ph_d = hbp_pkg::PH_PRECHARGE;
            is_high_d = 1'b1;
            cnt_d = hbp_pkg::CNT_W'(hbp_pkg::PRECHARGE_CYC);
          end else if (want_l) begin
            ph_d = hbp_pkg::PH_DELAY;
            is_high_d = 1'b0;
            cnt_d = dly_cyc + hbp_pkg::CNT_W'(hbp_pkg::DYNAMIC_DEGLITCH_CYC);
          end
        end
        hbp_pkg::PH_PRECHARGE: begin
          if (cnt_q <= 1) begin
            ph_d = hbp_pkg::PH_DELAY;
            cnt_d = dly_cyc + hbp_pkg::CNT_W'(hbp_pkg::DYNAMIC_DEGLITCH_CYC);
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        hbp_pkg::PH_DELAY: begin
          // Node sampled over the deglitch window that ends the delay
          if (cnt_q <= hbp_pkg::CNT_W'(hbp_pkg::DYNAMIC_DEGLITCH_CYC)
              && (is_high_q ? !rise_s[c] : !fall_s[c])) begin
            if (cnt_q <= 1) begin
              trip_dyn = 1'b1;
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end else if (cnt_q <= hbp_pkg::CNT_W'(hbp_pkg::DYNAMIC_DEGLITCH_CYC)) begin
            ph_d = hbp_pkg::PH_ON;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        hbp_pkg::PH_ON: begin
          sdg_d = cmp ? sdg_q + 1'b1 : '0;
          if (cmp && sdg_q + 1'b1 >= hbp_pkg::CNT_W'(hbp_pkg::STATIC_DEGLITCH_CYC)) begin
            trip_stat = 1'b1;
          end
        end
      endcase
      if (trip_dyn || trip_stat || !(is_high_q ? want_h : want_l)) begin
        ph_d = hbp_pkg::PH_IDLE;
        sdg_d = '0;
      end
      // Gates follow the phase; both off on a trip
      hg_d[c] = (ph_d != hbp_pkg::PH_IDLE) && is_high_d;
      lg_d[c] = (ph_d != hbp_pkg::PH_IDLE) && !is_high_d;
      // Shared flags, set beats read clear
      hflag_d[c] = ((trip_dyn || trip_stat) && is_high_q)
                   || (hflag_q[c] && !OVERLOAD_READ_CLR[c]);
      lflag_d[c] = ((trip_dyn || trip_stat) && !is_high_q)
                   || (lflag_q[c] && !OVERLOAD_READ_CLR[c]);
      qsb_d[c] = hflag_d[c] || lflag_d[c];
      // Fault lock lifts once flags are read and the enable is cleared, or on normal entry
      tripped_d[c] = trip_dyn || trip_stat
                     || (tripped_q[c] && (hflag_d[c] || lflag_d[c] || en_q[c]));
      if (clear_all) begin
        hflag_d[c] = 1'b0;
        lflag_d[c] = 1'b0;
        qsb_d[c] = 1'b0;
        tripped_d[c] = 1'b0;
      end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        ph_q <= hbp_pkg::PH_IDLE;
        cnt_q <= '0;
        sdg_q <= '0;
        is_high_q <= 1'b0;
      end else if (CLK_EN) begin
        ph_q <= ph_d;
        cnt_q <= cnt_d;
        sdg_q <= sdg_d;
        is_high_q <= is_high_d;
      end
    end

    // Test sources exist on odd bridges only (index 0, 2 are bridges 1, 3)
    if (c % 2 == 0 && c / 2 < 3) begin : g_tst
      // Normal mode with no global fault gates both enables
      assign HIGH_TEST_CURRENT_EN[c] = normal && !GLOBAL_FAULT && diag_q[2 * (c / 2)];
      assign LOW_TEST_CURRENT_EN[c] = normal && !GLOBAL_FAULT && diag_q[2 * (c / 2) + 1];
    end else begin : g_notst
      assign HIGH_TEST_CURRENT_EN[c] = 1'b0;
      assign LOW_TEST_CURRENT_EN[c] = 1'b0;
    end
  end

  // Flags hold across failsafe until a read clear or normal entry; gates drop to idle as requests are refused
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hflag_q <= '0;
      lflag_q <= '0;
      qsb_q <= '0;
      tripped_q <= '0;
      hg_q <= '0;
      lg_q <= '0;
    end else if (CLK_EN) begin
      hflag_q <= hflag_d;
      lflag_q <= lflag_d;
      qsb_q <= qsb_d;
      tripped_q <= tripped_d;
      hg_q <= hg_d;
      lg_q <= lg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; gates gated by mode for an immediate failsafe cut
  assign HIGH_SIDE_GATE_OUT = hg_q & {NUM_CH{normal}};
  assign LOW_SIDE_GATE_OUT = lg_q & {NUM_CH{normal}};
  assign HIGH_ACTIVE_PULLDOWN_EN = {NUM_CH{~|(HIGH_TEST_CURRENT_EN | LOW_TEST_CURRENT_EN)}};
  assign SWITCHED_PUMP_OUT = normal;
  assign PUMP_EN = normal;
  assign WRITE_ACCEPT = normal;
  assign MODE = mode_q;
  assign CFG_OUT = cfg_q;
  assign HIGH_OVERLOAD_FLAG = hflag_q;
  assign LOW_OVERLOAD_FLAG = lflag_q;
  assign BRIDGE_QUICK_STATUS = qsb_q;
  assign RESET_OCCURRED_FLAG = rcf_q;
  // Live, unlatched node comparators
  assign NODE_STATUS_REG = 8'(node_s);

endmodule : hbp_ctrl
`default_nettype wire

// ### tb/hbp_ctrl_props.sv
// Checker: port properties of the protection and mode block
`timescale 1ns/1ps
`default_nettype none
module hbp_ctrl_props #(
  parameter int unsigned NUM_CH = hbp_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Inputs
  input wire logic GLOBAL_FAULT,
  input wire logic CFG_WE,
  input wire hbp_pkg::hbp_cfg_type [NUM_CH-1:0] CFG_IN,
  // Outputs
  input wire logic [NUM_CH-1:0] HIGH_SIDE_GATE_OUT,
  input wire logic [NUM_CH-1:0] LOW_SIDE_GATE_OUT,
  input wire logic [NUM_CH-1:0] HIGH_ACTIVE_PULLDOWN_EN,
  input wire logic [NUM_CH-1:0] HIGH_TEST_CURRENT_EN,
  input wire logic [NUM_CH-1:0] LOW_TEST_CURRENT_EN,
  input wire logic SWITCHED_PUMP_OUT,
  input wire logic PUMP_EN,
  input wire logic WRITE_ACCEPT,
  input wire hbp_pkg::hbp_mode_type MODE,
  input wire hbp_pkg::hbp_cfg_type [NUM_CH-1:0] CFG_OUT,
  input wire logic [NUM_CH-1:0] HIGH_OVERLOAD_FLAG,
  input wire logic [NUM_CH-1:0] LOW_OVERLOAD_FLAG,
  input wire logic [NUM_CH-1:0] BRIDGE_QUICK_STATUS
);
  ////////////////////////////////////////
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // Per-channel summaries
  logic [NUM_CH-1:0] gates;
  logic [NUM_CH-1:0] tests;
  logic [NUM_CH-1:0] flags;
  assign gates = HIGH_SIDE_GATE_OUT | LOW_SIDE_GATE_OUT;
  assign tests = HIGH_TEST_CURRENT_EN | LOW_TEST_CURRENT_EN;
  assign flags = HIGH_OVERLOAD_FLAG | LOW_OVERLOAD_FLAG;
  ////////////////////////////////////////
  chk_sleep_quiet: assert property (
    MODE == hbp_pkg::MODE_SLEEP |-> gates == '0 && tests == '0)
    else $error("drive active in sleep");
  chk_failsafe_quiet: assert property (
    MODE == hbp_pkg::MODE_FAILSAFE |-> gates == '0 && tests == '0 && !SWITCHED_PUMP_OUT
      && !PUMP_EN && !WRITE_ACCEPT)
    else $error("drive active in failsafe");
  chk_test_gate: assert property (
    tests != '0 |-> MODE == hbp_pkg::MODE_NORMAL && !GLOBAL_FAULT)
    else $error("test current outside normal");
  chk_test_odd: assert property (
    (tests & ~{NUM_CH/2{2'h1}}) == '0)
    else $error("test current on even bridge");
  chk_pulldown_off: assert property (
    HIGH_ACTIVE_PULLDOWN_EN == {NUM_CH{tests == '0}})
    else $error("pulldown state wrong");
  chk_cfg_take: assert property (
    CFG_WE && MODE == hbp_pkg::MODE_NORMAL |=> CFG_OUT == $past(CFG_IN))
    else $error("config not taken");
  chk_fault_off: assert property (
    (flags & gates) == '0)
    else $error("flagged bridge driven");
  chk_quick_set: assert property (
    (flags & ~$past(flags) & ~BRIDGE_QUICK_STATUS) == '0)
    else $error("quick status missing");
endmodule : hbp_ctrl_props
bind hbp_ctrl hbp_ctrl_props #(.NUM_CH(NUM_CH)) u_hbp_ctrl_props (
  .CLK, .ARST_N, .GLOBAL_FAULT, .CFG_WE, .CFG_IN, .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT,
  .HIGH_ACTIVE_PULLDOWN_EN, .HIGH_TEST_CURRENT_EN, .LOW_TEST_CURRENT_EN, .SWITCHED_PUMP_OUT,
  .PUMP_EN, .WRITE_ACCEPT, .MODE, .CFG_OUT, .HIGH_OVERLOAD_FLAG, .LOW_OVERLOAD_FLAG,
  .BRIDGE_QUICK_STATUS
);
`default_nettype wire

// ### tb/hbp_bridge_model.sv
// Model: external half-bridge stage and its comparators
`timescale 1ns/1ps
`default_nettype none
module hbp_bridge_model (
  // Clock
  input wire logic CLK,
  // Gate drive and injected faults
  input wire logic [3:0] HIGH_SIDE_GATE_OUT,
  input wire logic [3:0] LOW_SIDE_GATE_OUT,
  input wire logic [3:0] SHORT_MASK,
  input wire logic [3:0] LOAD_MASK,
  // Comparator levels
  output logic [3:0] NODE_RISE_CMP,
  output logic [3:0] NODE_FALL_CMP,
  output logic [3:0] HIGH_OVERLOAD_CMP,
  output logic [3:0] LOW_OVERLOAD_CMP
);
  logic [3:0] node_q;
  // Node follows the driven gate a cycle late; a shorted node is stuck
  always @(posedge CLK) begin
    for (int i = 0; i < 4; i++) begin
      if (SHORT_MASK[i] === 1'b1) node_q[i] <= node_q[i];
      else if (HIGH_SIDE_GATE_OUT[i]) node_q[i] <= 1'b1;
      else if (LOW_SIDE_GATE_OUT[i] || node_q[i] === 1'bx) node_q[i] <= 1'b0;
    end
  end
  // Overload shows only across a switch that is on
  assign NODE_RISE_CMP = node_q;
  assign NODE_FALL_CMP = ~node_q;
  assign HIGH_OVERLOAD_CMP = LOAD_MASK & HIGH_SIDE_GATE_OUT;
  assign LOW_OVERLOAD_CMP = LOAD_MASK & LOW_SIDE_GATE_OUT;
endmodule : hbp_bridge_model
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: directed checks of protection, test currents and modes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK, ARST_N, RESET_N_IN, FAILSAFE_REQUEST_IN, SERIAL_FAILURE, WATCHDOG_TOGGLE_BIT;
  logic GLOBAL_FAULT, CFG_WE, RESET_FLAG_READ_CLR, SWITCHED_PUMP_OUT, PUMP_EN, WRITE_ACCEPT;
  logic RESET_OCCURRED_FLAG;
  hbp_pkg::hbp_cfg_type [3:0] CFG_IN, CFG_OUT;
  hbp_pkg::hbp_gate_type [3:0] GATE_REQ;
  hbp_pkg::hbp_mode_type MODE;
  logic [3:0] BRIDGE_ENABLE_BIT, HIGH_OVERLOAD_CMP, LOW_OVERLOAD_CMP, NODE_RISE_CMP;
  logic [3:0] NODE_FALL_CMP, OVERLOAD_READ_CLR, HIGH_SIDE_GATE_OUT, LOW_SIDE_GATE_OUT;
  logic [3:0] HIGH_ACTIVE_PULLDOWN_EN, HIGH_TEST_CURRENT_EN, LOW_TEST_CURRENT_EN;
  logic [3:0] HIGH_OVERLOAD_FLAG, LOW_OVERLOAD_FLAG, BRIDGE_QUICK_STATUS, short_m, load_m;
  logic [5:0] DIAG_CONTROL_IN;
  logic [7:0] BRIDGE_NODE_SENSE, NODE_STATUS_REG;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////
  // Block under test and its power stage
  hbp_ctrl u_hbp_ctrl (.CLK, .ARST_N, .CLK_EN(1'b1), .RESET_N_IN, .FAILSAFE_REQUEST_IN,
    .SERIAL_FAILURE, .WATCHDOG_TOGGLE_BIT, .GLOBAL_FAULT, .CFG_WE, .CFG_IN, .BRIDGE_ENABLE_BIT,
    .DIAG_CONTROL_IN, .GATE_REQ, .HIGH_OVERLOAD_CMP, .LOW_OVERLOAD_CMP, .NODE_RISE_CMP,
    .NODE_FALL_CMP, .BRIDGE_NODE_SENSE, .OVERLOAD_READ_CLR, .HIGH_SIDE_GATE_OUT,
    .LOW_SIDE_GATE_OUT, .HIGH_ACTIVE_PULLDOWN_EN, .HIGH_TEST_CURRENT_EN, .LOW_TEST_CURRENT_EN,
    .SWITCHED_PUMP_OUT, .PUMP_EN, .WRITE_ACCEPT, .MODE, .CFG_OUT, .HIGH_OVERLOAD_FLAG,
    .LOW_OVERLOAD_FLAG, .BRIDGE_QUICK_STATUS, .RESET_OCCURRED_FLAG, .RESET_FLAG_READ_CLR,
    .NODE_STATUS_REG);
  hbp_bridge_model u_hbp_bridge_model (.CLK, .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT,
    .SHORT_MASK(short_m), .LOAD_MASK(load_m), .NODE_RISE_CMP, .NODE_FALL_CMP,
    .HIGH_OVERLOAD_CMP, .LOW_OVERLOAD_CMP);
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : ticks
  // Mode changes pass a pin synchroniser, so allow a short bounded wait
  task automatic wait_mode(input hbp_pkg::hbp_mode_type m);
    for (int n = 0; n < 12 && MODE !== m; n++) ticks(1);
    chk("mode", m, MODE);
  endtask : wait_mode
  task automatic cfg(input logic [6:0] f, input logic [3:0] en, input logic [5:0] dg);
    @(posedge CLK);
    CFG_WE <= 1'b1;
    CFG_IN <= {4{f}};
    BRIDGE_ENABLE_BIT <= en;
    DIAG_CONTROL_IN <= dg;
    ticks(1);
    CFG_WE <= 1'b0;
  endtask : cfg
  task automatic clr(input logic [3:0] ov, input logic rf);
    @(posedge CLK);
    OVERLOAD_READ_CLR <= ov;
    RESET_FLAG_READ_CLR <= rf;
    @(posedge CLK);
    OVERLOAD_READ_CLR <= 4'h0;
    RESET_FLAG_READ_CLR <= 1'b0;
    #1;
  endtask : clr
  ////////////////////////////////////////
  // Free-running clock and hang guard
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    {ARST_N, RESET_N_IN, FAILSAFE_REQUEST_IN, SERIAL_FAILURE, WATCHDOG_TOGGLE_BIT} = 5'h00;
    {GLOBAL_FAULT, CFG_WE, RESET_FLAG_READ_CLR, short_m, load_m} = 11'h000;
    {CFG_IN, GATE_REQ, BRIDGE_ENABLE_BIT, OVERLOAD_READ_CLR} = 44'h0;
    DIAG_CONTROL_IN = 6'h00;
    BRIDGE_NODE_SENSE = 8'h00;
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    ticks(4);
    chk("sleep", hbp_pkg::MODE_SLEEP, MODE);
    chk("pulldown", 32'hF, HIGH_ACTIVE_PULLDOWN_EN);
    @(posedge CLK) RESET_N_IN <= 1'b1;
    wait_mode(hbp_pkg::MODE_NORMAL);
    chk("rcf", 32'h1, RESET_OCCURRED_FLAG);
    chk("pump", 32'h1, SWITCHED_PUMP_OUT);
    clr(4'h0, 1'b1);
    chk("rcf clr", 32'h0, RESET_OCCURRED_FLAG);
    cfg(7'h50, 4'hF, 6'h00);
    chk("cfg", 32'hA142850, CFG_OUT);
    cfg(7'h29, 4'hF, 6'h00);
    chk("cfg", 32'h52A54A9, CFG_OUT);
    cfg(7'h00, 4'hF, 6'h00);
    BRIDGE_NODE_SENSE <= 8'hA5;
    ticks(4);
    chk("node", 32'hA5, NODE_STATUS_REG);
    // Clean high then low turn-on, then a shorted high turn-on
    @(posedge CLK) GATE_REQ <= 8'h02;
    ticks(60);
    chk("hs on", 32'h1, HIGH_SIDE_GATE_OUT | {3'h0, HIGH_OVERLOAD_FLAG[0]});
    @(posedge CLK) GATE_REQ <= 8'h01;
    ticks(60);
    chk("ls on", 32'h1, LOW_SIDE_GATE_OUT | {3'h0, LOW_OVERLOAD_FLAG[0]});
    @(posedge CLK) GATE_REQ <= 8'h02;
    short_m <= 4'h1;
    ticks(20);
    chk("hs delay", 32'h1, HIGH_SIDE_GATE_OUT);
    ticks(40);
    chk("dyn trip", 32'h10, {HIGH_OVERLOAD_FLAG, HIGH_SIDE_GATE_OUT});
    chk("quick", 32'h1, BRIDGE_QUICK_STATUS);
    cfg(7'h00, 4'h0, 6'h00);
    cfg(7'h00, 4'hF, 6'h00);
    ticks(30);
    chk("locked", 32'h0, HIGH_SIDE_GATE_OUT);
    short_m <= 4'h0;
    clr(4'hF, 1'b0);
    chk("flag clr", 32'h0, HIGH_OVERLOAD_FLAG);
    cfg(7'h00, 4'h0, 6'h00);
    cfg(7'h00, 4'hF, 6'h06);
    chk("tests", 32'h41, {HIGH_TEST_CURRENT_EN, LOW_TEST_CURRENT_EN});
    cfg(7'h00, 4'hF, 6'h3F);
    chk("tests", 32'h550, {HIGH_TEST_CURRENT_EN, LOW_TEST_CURRENT_EN, HIGH_ACTIVE_PULLDOWN_EN});
    @(posedge CLK) GLOBAL_FAULT <= 1'b1;
    ticks(1);
    chk("blocked", 32'h00F, {HIGH_TEST_CURRENT_EN, LOW_TEST_CURRENT_EN, HIGH_ACTIVE_PULLDOWN_EN});
    GLOBAL_FAULT <= 1'b0;
    ticks(30);
    chk("restart", 32'h1, HIGH_SIDE_GATE_OUT);
    // Static overload on the running high side
    load_m <= 4'h1;
    ticks(100);
    chk("deglitch", 32'h1, HIGH_SIDE_GATE_OUT);
    ticks(60);
    chk("stat trip", 32'h10, {HIGH_OVERLOAD_FLAG, HIGH_SIDE_GATE_OUT});
    load_m <= 4'h0;
    // Failsafe by request, then by serial failure
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK);
      FAILSAFE_REQUEST_IN <= (k == 0);
      SERIAL_FAILURE <= (k == 1);
      wait_mode(hbp_pkg::MODE_FAILSAFE);
      chk("fs outs", 32'h0, {HIGH_TEST_CURRENT_EN, PUMP_EN, WRITE_ACCEPT});
      if (k == 0) chk("kept", 32'h1, HIGH_OVERLOAD_FLAG);
      cfg(7'h7F, 4'hF, 6'h3F);
      chk("fs write", 32'h0, CFG_OUT);
      FAILSAFE_REQUEST_IN <= 1'b0;
      SERIAL_FAILURE <= 1'b0;
      ticks(6);
      chk("fs hold", hbp_pkg::MODE_FAILSAFE, MODE);
      WATCHDOG_TOGGLE_BIT <= ~WATCHDOG_TOGGLE_BIT;
      wait_mode(hbp_pkg::MODE_NORMAL);
      chk("rcf", 32'h1, RESET_OCCURRED_FLAG);
    end
    cfg(7'h00, 4'hF, 6'h00);
    ticks(40);
    RESET_N_IN <= 1'b0;
    wait_mode(hbp_pkg::MODE_SLEEP);
    chk("sleep outs", 32'h0, {HIGH_SIDE_GATE_OUT, SWITCHED_PUMP_OUT});
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
